/* File: rtl/mirq_pkg.sv */
// mirq_pkg: register map, bit layout, phase and latency constants and the
// packed carriers of the microcontroller interrupt logic.
// assumes one instruction cycle is four clocks, one clock per q phase.
package mirq_pkg;

  // register addresses; the control register is mirrored in four banks
  localparam int         ADDR_W       = 9;
  localparam logic [8:0] CTRL_ADDR_B0 = 9'h00B;
  localparam logic [8:0] CTRL_ADDR_B1 = 9'h08B;
  localparam logic [8:0] CTRL_ADDR_B2 = 9'h10B;
  localparam logic [8:0] CTRL_ADDR_B3 = 9'h18B;
  localparam logic [8:0] FLAGS_ADDR   = 9'h00C;
  localparam logic [8:0] ENABLES_ADDR = 9'h08C;

  // irq_control bit positions
  localparam int GLOBAL_IRQ_ENABLE      = 7;
  localparam int PERIPHERAL_IRQ_ENABLE  = 6;
  localparam int TIMER0_OVERFLOW_ENABLE = 5;
  localparam int EXT_PIN_IRQ_ENABLE     = 4;
  localparam int PORT_CHANGE_ENABLE     = 3;
  localparam int TIMER0_OVERFLOW_FLAG   = 2;
  localparam int EXT_PIN_IRQ_FLAG       = 1;
  localparam int PORT_CHANGE_FLAG       = 0;

  // peripheral flag / enable bit positions
  localparam int EEPROM_DONE_FLAG     = 7;
  localparam int COMPARATOR_FLAG      = 6;
  localparam int SERIAL_RX_FLAG       = 5;
  localparam int SERIAL_TX_FLAG       = 4;
  localparam int CAPTURE_COMPARE_FLAG = 2;
  localparam int TIMER2_MATCH_FLAG    = 1;
  localparam int TIMER1_OVERFLOW_FLAG = 0;
  localparam logic [7:0] PERIPH_IMPL_MASK = 8'hF7;

  // reset values and timer0 wrap values
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] PERIPH_RST  = 8'h00;
  localparam logic [7:0] T0_WRAP_OLD = 8'hFF;
  localparam logic [7:0] T0_WRAP_NEW = 8'h00;

  // vector and phases
  localparam int          PC_W        = 13;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  localparam logic [1:0]  PH_Q1       = 2'h0;
  localparam logic [1:0]  PH_Q2       = 2'h1;
  localparam logic [1:0]  PH_Q3       = 2'h2;
  localparam logic [1:0]  PH_Q4       = 2'h3;
  localparam int          CLKS_PER_TCY = 4;
  localparam int          LATENCY_TCY  = 3;
  localparam int          HOLDOFF_TCY  = 1;
  localparam int          CNT_W        = 6;

  typedef enum logic [1:0] {
    LAT_IDLE    = 2'b00,
    LAT_COUNT   = 2'b01,
    LAT_HOLDOFF = 2'b10
  } mirq_lat_t;

  // signals from the processor core sequencer
  typedef struct packed {
    logic return_from_irq_instr; // one-cycle pulse
    logic sleeping;              // level
    logic port_read;             // pulse, port data latched on read
    logic ext_edge_select;       // option bit 6, 1 = rising
  } mirq_core_in_t;

  // signals to the processor core sequencer
  typedef struct packed {
    logic            vector_take;   // pulse: push return pc, load vector
    logic [PC_W-1:0] vector_addr;
    logic            nop_insert;    // level for one instruction cycle
    logic            wake;
    logic            sleep_inhibit;
    logic            irq_pending;
    logic [1:0]      phase;
  } mirq_core_out_t;

  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] ctrl;
    logic [7:0] pflags;
    logic [7:0] penab;
    logic       ext_s1;
    logic       ext_s2;
    logic       ext_prev;
    logic       edge_hold;
    logic [3:0] port_s1;
    logic [3:0] port_s2;
    logic [3:0] port_latch;
    logic [7:0] t0_prev;
    mirq_lat_t  lat;
    logic [CNT_W-1:0] cnt;
    logic [7:0] rdata;
    logic       take;
    logic       nop;
    logic       wake;
    logic       sleep_inh;
    logic       pending;
  } mirq_state_t;

endpackage

/* File: rtl/mirq_logic.sv */
// mirq_logic: interrupt flags, enables, vector timing and wake logic of an
// 8-bit microcontroller.
// assumes core, timer0 and peripherals share this clock; pins are async.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

// Behaviour
// (R1) global enable gates every interrupt to core
// (R2) reset clears global enable
// (R3) return-from-interrupt sets global enable again
// (R4) peripheral flags 0Ch, enables 8Ch, bit3 unused
// (R5) peripheral needs own and peripheral enable
// (R6) take: clear global enable, push, vector 0004h
// (R7) async events reach vector in 3-4 cycles
// (R8) synchronous events reach vector in 3 cycles
// (R9) latency independent of instruction length
// (R10) flags set regardless of any enable
// (R11) after clearing global enable, ignore one cycle
// (R12) external pin edge, polarity by edge select
// (R13) pin edge sets flag, its enable masks
// (R14) enabled pin edge wakes from sleep
// (R15) pin flag sampled Q1, set during Q4-Q1
// (R16) timer0 wrap FFh to 00h sets flag
// (R17) change on port pins 7:4 sets flag
// (R18) change during port read may be missed
// (R19) software clears flags before re-enabling
// (R20) only return pc saved on entry
// (R21) reset values 0000000x and 0000-000
// (R22) wake with global enable loads vector
module mirq_logic #(
  parameter int LATENCY_TCY = mirq_pkg::LATENCY_TCY
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   rst_is_por,
  // register port
  input  wire logic [8:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // device pins
  input  wire logic                   ext_irq_pin,
  input  wire logic [3:0]             port_pins_hi,
  // request sources
  input  wire logic [7:0]             timer0_count,
  input  wire logic [7:0]             periph_req,
  // core sequencer
  input  wire mirq_pkg::mirq_core_in_t  core_in,
  output mirq_pkg::mirq_core_out_t      core_out
);

  localparam logic [mirq_pkg::CNT_W-1:0] TAKE_CLKS =
    mirq_pkg::CNT_W'(LATENCY_TCY * mirq_pkg::CLKS_PER_TCY);
  localparam logic [mirq_pkg::CNT_W-1:0] HOLD_CLKS =
    mirq_pkg::CNT_W'(mirq_pkg::HOLDOFF_TCY * mirq_pkg::CLKS_PER_TCY);

  // elaboration check: the clock countdown must fit in cnt
  if (LATENCY_TCY < 1 ||
      LATENCY_TCY * mirq_pkg::CLKS_PER_TCY >=
      (1 << mirq_pkg::CNT_W)) begin : g_bad_latency
    $error("mirq_logic: LATENCY_TCY out of range");
  end

  mirq_pkg::mirq_state_t s_q;
  mirq_pkg::mirq_state_t s_d;

  // decoded register accesses
  logic       ctrl_sel;
  logic       flags_sel;
  logic       enab_sel;
  logic       ctrl_wr;
  logic       gie_cleared_by_sw;
  // event detection
  logic       ext_edge;
  logic       ext_load;
  logic       port_change;
  logic       t0_wrap;
  // request evaluation
  logic       core_enabled_req;
  logic       periph_enabled_req;
  logic       any_enabled_req;
  logic       deliverable;
  logic       take_now;

  always_comb begin
    if (reg_addr == mirq_pkg::CTRL_ADDR_B0 ||
        reg_addr == mirq_pkg::CTRL_ADDR_B1 ||
        reg_addr == mirq_pkg::CTRL_ADDR_B2 ||
        reg_addr == mirq_pkg::CTRL_ADDR_B3) begin
      ctrl_sel  = 1'b1;
      flags_sel = 1'b0;
      enab_sel  = 1'b0;
    end else if (reg_addr == mirq_pkg::FLAGS_ADDR) begin
      ctrl_sel  = 1'b0;
      flags_sel = 1'b1;
      enab_sel  = 1'b0;
    end else if (reg_addr == mirq_pkg::ENABLES_ADDR) begin
      ctrl_sel  = 1'b0;
      flags_sel = 1'b0;
      enab_sel  = 1'b1;
    end else begin
      ctrl_sel  = 1'b0;
      flags_sel = 1'b0;
      enab_sel  = 1'b0;
    end
  end

  assign ctrl_wr = reg_wr & ctrl_sel;
  // a write that drops the global enable starts the ignore cycle
  assign gie_cleared_by_sw = ctrl_wr
    & s_q.ctrl[mirq_pkg::GLOBAL_IRQ_ENABLE]
    & ~reg_wdata[mirq_pkg::GLOBAL_IRQ_ENABLE];

  // edge on the synchronised pin, polarity chosen by software
  assign ext_edge = core_in.ext_edge_select
    ? (s_q.ext_s2 & ~s_q.ext_prev)
    : (~s_q.ext_s2 & s_q.ext_prev);                            // [R12]

  // flag may only load in Q4 or Q1; earlier edges wait in edge_hold
  assign ext_load = (ext_edge | s_q.edge_hold) &
    (s_q.phase == mirq_pkg::PH_Q4 || s_q.phase == mirq_pkg::PH_Q1); // [R15]

  // a change racing a port read in Q2 is lost, as the latch refreshes
  assign port_change = (s_q.port_s2 != s_q.port_latch) &
    ~(core_in.port_read && s_q.phase == mirq_pkg::PH_Q2);      // [R17] [R18]

  assign t0_wrap = (s_q.t0_prev == mirq_pkg::T0_WRAP_OLD) &&
    (timer0_count == mirq_pkg::T0_WRAP_NEW);                   // [R16]

  always_comb begin
    core_enabled_req =
      (s_q.ctrl[mirq_pkg::EXT_PIN_IRQ_ENABLE] &
       s_q.ctrl[mirq_pkg::EXT_PIN_IRQ_FLAG]) |                  // [R13]
      (s_q.ctrl[mirq_pkg::TIMER0_OVERFLOW_ENABLE] &
       s_q.ctrl[mirq_pkg::TIMER0_OVERFLOW_FLAG]) |              // [R16]
      (s_q.ctrl[mirq_pkg::PORT_CHANGE_ENABLE] &
       s_q.ctrl[mirq_pkg::PORT_CHANGE_FLAG]);                   // [R17]
    periph_enabled_req =
      s_q.ctrl[mirq_pkg::PERIPHERAL_IRQ_ENABLE] &
      (|(s_q.pflags & s_q.penab & mirq_pkg::PERIPH_IMPL_MASK)); // [R5]
    any_enabled_req = core_enabled_req | periph_enabled_req;
    deliverable = any_enabled_req &
      s_q.ctrl[mirq_pkg::GLOBAL_IRQ_ENABLE];                    // [R1]
  end

  // the countdown is in clocks, so instruction length never matters
  assign take_now = (s_q.lat == mirq_pkg::LAT_COUNT) &&
    (s_q.cnt == mirq_pkg::CNT_W'(1)) && deliverable;           // [R8] [R9]

  always_comb begin
    s_d = s_q;

    // free running q phase counter
    s_d.phase = s_q.phase + 2'h1;

    // synchronisers: first stage read only by the second
    s_d.ext_s1   = ext_irq_pin;
    s_d.ext_s2   = s_q.ext_s1;
    s_d.ext_prev = s_q.ext_s2;
    s_d.port_s1  = port_pins_hi;
    s_d.port_s2  = s_q.port_s1;
    s_d.t0_prev  = timer0_count;

    // pin edge parked until the Q4-Q1 window
    if (ext_load) begin
      s_d.edge_hold = 1'b0;
    end else if (ext_edge) begin
      s_d.edge_hold = 1'b1;                                    // [R15]
    end

    if (core_in.port_read) begin
      s_d.port_latch = s_q.port_s2;
    end

    // control register: software write, then hardware sets win
    if (ctrl_wr) begin
      s_d.ctrl = reg_wdata;
    end
    if (ext_load) begin
      s_d.ctrl[mirq_pkg::EXT_PIN_IRQ_FLAG] = 1'b1;             // [R10] [R13]
    end
    if (t0_wrap) begin
      s_d.ctrl[mirq_pkg::TIMER0_OVERFLOW_FLAG] = 1'b1;         // [R10] [R16]
    end
    if (port_change) begin
      s_d.ctrl[mirq_pkg::PORT_CHANGE_FLAG] = 1'b1;             // [R10] [R17]
    end
    if (core_in.return_from_irq_instr) begin
      s_d.ctrl[mirq_pkg::GLOBAL_IRQ_ENABLE] = 1'b1;            // [R3]
    end
    if (take_now) begin
      s_d.ctrl[mirq_pkg::GLOBAL_IRQ_ENABLE] = 1'b0;            // [R6]
    end

    // peripheral flags: set wins over a clearing write
    if (reg_wr && flags_sel) begin
      s_d.pflags = reg_wdata & mirq_pkg::PERIPH_IMPL_MASK;     // [R4]
    end
    s_d.pflags = s_d.pflags |
      (periph_req & mirq_pkg::PERIPH_IMPL_MASK);               // [R10]
    if (reg_wr && enab_sel) begin
      s_d.penab = reg_wdata & mirq_pkg::PERIPH_IMPL_MASK;      // [R4]
    end

    // read data stands one cycle after the strobe
    if (reg_rd) begin
      if (ctrl_sel) begin
        s_d.rdata = s_q.ctrl;
      end else if (flags_sel) begin
        s_d.rdata = s_q.pflags & mirq_pkg::PERIPH_IMPL_MASK;   // [R4]
      end else if (enab_sel) begin
        s_d.rdata = s_q.penab & mirq_pkg::PERIPH_IMPL_MASK;
      end else begin
        s_d.rdata = 8'h00;
      end
    end else begin
      s_d.rdata = 8'h00;
    end

    // vectoring sequence
    s_d.take = 1'b0;
    s_d.nop  = 1'b0;
    case (s_q.lat)
      mirq_pkg::LAT_IDLE: begin
        // requests are sampled at Q1 only; async arrivals add 0-1 cycle
        if (deliverable && !core_in.sleeping &&
            s_q.phase == mirq_pkg::PH_Q1) begin                // [R7] [R22]
          s_d.lat = mirq_pkg::LAT_COUNT;
          s_d.cnt = TAKE_CLKS;
        end
      end
      mirq_pkg::LAT_COUNT: begin
        if (!deliverable) begin
          s_d.lat = mirq_pkg::LAT_IDLE;
        end else if (s_q.cnt == mirq_pkg::CNT_W'(1)) begin
          // only the return pc is pushed by the core on this pulse
          s_d.take = 1'b1;                                     // [R6] [R20]
          s_d.lat  = mirq_pkg::LAT_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - mirq_pkg::CNT_W'(1);
        end
      end
      mirq_pkg::LAT_HOLDOFF: begin
        s_d.nop = 1'b1;
        if (s_q.cnt == mirq_pkg::CNT_W'(1)) begin
          s_d.lat = mirq_pkg::LAT_IDLE;
          s_d.nop = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - mirq_pkg::CNT_W'(1);
        end
      end
      default: begin
        s_d.lat = mirq_pkg::LAT_IDLE;
      end
    endcase

    // flags stay set, so ignored requests return once enable is back
    if (gie_cleared_by_sw) begin
      s_d.lat  = mirq_pkg::LAT_HOLDOFF;                        // [R11]
      s_d.cnt  = HOLD_CLKS;
      s_d.nop  = 1'b1;
      s_d.take = 1'b0;
    end

    // wake needs the individual enable, plus the peripheral enable for peripheral sources, but not the global one
    s_d.wake      = core_in.sleeping & any_enabled_req;        // [R14]
    s_d.sleep_inh = ~s_q.ctrl[mirq_pkg::GLOBAL_IRQ_ENABLE] &
      any_enabled_req;
    s_d.pending   = any_enabled_req;

    if (rst) begin
      s_d.phase = mirq_pkg::PH_Q1;
      // port-change flag survives all but power-on reset
      s_d.ctrl = mirq_pkg::CTRL_RST;                           // [R2] [R21]
      if (!rst_is_por) begin
        s_d.ctrl[mirq_pkg::PORT_CHANGE_FLAG] =
          s_q.ctrl[mirq_pkg::PORT_CHANGE_FLAG];                // [R21]
      end
      s_d.pflags     = mirq_pkg::PERIPH_RST;                   // [R21]
      s_d.penab      = mirq_pkg::PERIPH_RST;
      s_d.ext_prev   = s_q.ext_s2;
      s_d.edge_hold  = 1'b0;
      s_d.port_latch = s_q.port_s2;
      s_d.lat        = mirq_pkg::LAT_IDLE;
      s_d.cnt        = '0;
      s_d.rdata      = 8'h00;
      s_d.take       = 1'b0;
      s_d.nop        = 1'b0;
      s_d.wake       = 1'b0;
      s_d.sleep_inh  = 1'b0;
      s_d.pending    = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    s_q <= s_d;
  end

  assign reg_rdata              = s_q.rdata;
  assign core_out.vector_take   = s_q.take;
  assign core_out.vector_addr   = mirq_pkg::VECTOR_ADDR;       // [R6]
  assign core_out.nop_insert    = s_q.nop;
  assign core_out.wake          = s_q.wake;
  assign core_out.sleep_inhibit = s_q.sleep_inh;
  assign core_out.irq_pending   = s_q.pending;
  assign core_out.phase         = s_q.phase;

endmodule

/* File: tb/mirq_monitor.sv */
// mirq_monitor: port-level assertions for mirq_logic.
// assumes one clock and synchronous active-high rst.
`timescale 1ns/1ps
module mirq_monitor #(
  parameter int LATENCY_TCY = 3
) (
  // clock and reset
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    rst_is_por,
  // register port
  input wire logic [8:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  // pins and sources
  input wire logic                    ext_irq_pin,
  input wire logic [3:0]              port_pins_hi,
  input wire logic [7:0]              timer0_count,
  input wire logic [7:0]              periph_req,
  // core sequencer
  input wire mirq_pkg::mirq_core_in_t  core_in,
  input wire mirq_pkg::mirq_core_out_t core_out
);
  logic pmap;
  assign pmap = reg_addr == 9'h00C || reg_addr == 9'h08C;
  logic mapped;
  assign mapped = pmap || reg_addr[6:0] == 7'h0B;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_vec; core_out.vector_addr == 13'h0004; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray rdata");
  property p_unmap; $past(reg_rd && !mapped) |-> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_bit3; $past(reg_rd && pmap) |-> reg_rdata[3] == 1'b0;
  endproperty
  a_bit3: assert property (p_bit3) else $error("bit3 set");
  property p_phase;
    !$past(rst) |-> core_out.phase == $past(core_out.phase) + 2'h1;
  endproperty
  a_phase: assert property (p_phase) else $error("phase");
  property p_gap; core_out.vector_take |=> !core_out.vector_take [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("retake");
  property p_nop;
    $rose(core_out.nop_insert) |-> core_out.nop_insert [*4]
      ##1 !core_out.nop_insert;
  endproperty
  a_nop: assert property (p_nop) else $error("nop length");
  property p_noptk; core_out.nop_insert |-> !core_out.vector_take;
  endproperty
  a_noptk: assert property (p_noptk) else $error("take in nop");
  property p_wake; core_out.wake |-> $past(core_in.sleeping); endproperty
  a_wake: assert property (p_wake) else $error("wake awake");
  property p_pend; core_out.vector_take |-> core_out.irq_pending;
  endproperty
  a_pend: assert property (p_pend) else $error("take no req");
  c_take: cover property (core_out.vector_take);
  c_nop: cover property ($rose(core_out.nop_insert));
  c_wake: cover property (core_out.wake);
endmodule
bind mirq_logic mirq_monitor #(.LATENCY_TCY(LATENCY_TCY)) u_mirq_monitor (
  .clock(clock), .rst(rst), .rst_is_por(rst_is_por),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin),
  .port_pins_hi(port_pins_hi), .timer0_count(timer0_count),
  .periph_req(periph_req), .core_in(core_in), .core_out(core_out));

/* File: tb/mirq_core_model.sv */
// mirq_core_model: core sequencer stand-in: return, sleep, port reads.
// assumes bench requests are one-cycle pulses on clock.
`timescale 1ns/1ps
module mirq_core_model (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // bench requests
  input  wire logic                    ret_req,
  input  wire logic                    sleep_req,
  input  wire logic                    edge_sel,
  input  wire logic                    read_req,
  // design side
  input  wire mirq_pkg::mirq_core_out_t core_out,
  output mirq_pkg::mirq_core_in_t      core_in,
  output logic [2:0]                   depth_q
);
  logic asleep_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      depth_q <= 3'h0;
      asleep_q <= 1'b0;
    end else begin
      if (core_out.vector_take) begin
        depth_q <= depth_q + 3'h1;
      end else if (core_in.return_from_irq_instr) begin
        depth_q <= depth_q - 3'h1;
      end
      // sleep refused while a masked-off request waits
      if (sleep_req) begin
        asleep_q <= !core_out.sleep_inhibit;
      end else if (core_out.wake) begin
        asleep_q <= 1'b0;
      end
    end
  end
  always_comb begin
    core_in.return_from_irq_instr = ret_req && depth_q != 3'h0;
    core_in.sleeping = asleep_q;
    core_in.port_read = read_req;
    core_in.ext_edge_select = edge_sel;
  end
endmodule

/* File: tb/mirq_logic_test.sv */
// mirq_logic_test: self-checking bench for mirq_logic.
// assumes mirq_core_model on the core side; bench drives pins and bus.
`timescale 1ns/1ps
module mirq_logic_test;
  typedef struct packed {
    logic [8:0] wa;
    logic [7:0] wd;
    logic [8:0] ra;
    logic [7:0] ex;
  } mirq_row_t;
  localparam mirq_row_t ROWS [6] = '{
    '{9'h08C, 8'hFF, 9'h08C, 8'hF7}, '{9'h00C, 8'hFF, 9'h00C, 8'hF7},
    '{9'h00C, 8'h00, 9'h00C, 8'h00}, '{9'h08B, 8'h38, 9'h18B, 8'h38},
    '{9'h10B, 8'h00, 9'h00B, 8'h00}, '{9'h0AA, 8'hFF, 9'h0AA, 8'h00}};
  logic       clock, rst, rst_is_por, reg_wr, reg_rd, ext_irq_pin;
  logic       ret_req, sleep_req, edge_sel, read_req;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, timer0_count, periph_req;
  logic [3:0] port_pins_hi;
  logic [2:0] depth;
  int         checks, miscompares, n;
  mirq_pkg::mirq_core_in_t  core_in;
  mirq_pkg::mirq_core_out_t core_out;
  mirq_logic u_mirq_logic (.clock(clock), .rst(rst),
    .rst_is_por(rst_is_por), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq_pin(ext_irq_pin), .port_pins_hi(port_pins_hi),
    .timer0_count(timer0_count), .periph_req(periph_req),
    .core_in(core_in), .core_out(core_out));
  mirq_core_model u_mirq_core_model (.clock(clock), .rst(rst),
    .ret_req(ret_req), .sleep_req(sleep_req), .edge_sel(edge_sel),
    .read_req(read_req), .core_out(core_out), .core_in(core_in),
    .depth_q(depth));
  always #25 clock = !clock;
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] ex);
    checks++;
    if (seen !== ex) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, ex);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [7:0] ex);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, ex);
    @(posedge clock);
  endtask
  task automatic pulse_ret;
    ret_req <= 1'b1;
    @(posedge clock);
    ret_req <= 1'b0;
    cyc(2);
  endtask
  task automatic wrap;
    timer0_count <= 8'hFF;
    @(posedge clock);
    timer0_count <= 8'h00;
    cyc(12);
  endtask
  task automatic wait_take(output int k);
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (core_out.vector_take !== 1'b1 && k < 60);
    // let the model's depth update settle before anyone reads it
    cyc(2);
  endtask
  task automatic do_reset(input logic por);
    rst <= 1'b1;
    rst_is_por <= por;
    cyc(16);
    rst <= 1'b0;
    cyc(1);
  endtask
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
  initial begin
    {clock, rst, rst_is_por, reg_wr, reg_rd, ext_irq_pin} = '0;
    {ret_req, sleep_req, edge_sel, read_req, reg_addr} = '0;
    {reg_wdata, timer0_count, periph_req, port_pins_hi} = '0;
    do_reset(1'b1);
    foreach (ROWS[i]) begin
      wr(ROWS[i].wa, ROWS[i].wd);
      rdchk(ROWS[i].ra, ROWS[i].ex);
    end
    wrap;
    rdchk(9'h00B, 8'h04);
    wr(9'h00B, 8'h24);
    cyc(30);
    chk({5'h0, depth}, 8'h00);
    wr(9'h00B, 8'hA4);
    wait_take(n);
    chk({7'h0, n >= 14 && n <= 18}, 8'h01);
    rdchk(9'h00B, 8'h24);
    chk({5'h0, depth}, 8'h01);
    wr(9'h00B, 8'h20);
    pulse_ret;
    rdchk(9'h00B, 8'hA0);
    wr(9'h00B, 8'h20);
    wrap;
    cyc(20);
    chk({5'h0, depth}, 8'h00);
    wr(9'h10B, 8'hA4);
    wait_take(n);
    chk({5'h0, depth}, 8'h01);
    wr(9'h00B, 8'h00);
    pulse_ret;
    periph_req <= 8'h01;
    @(posedge clock);
    periph_req <= 8'h00;
    cyc(2);
    rdchk(9'h00C, 8'h01);
    wr(9'h08C, 8'h01);
    cyc(1);
    wr(9'h00B, 8'h80);
    cyc(30);
    chk({5'h0, depth}, 8'h00);
    wr(9'h00B, 8'hC0);
    wait_take(n);
    chk({5'h0, depth}, 8'h01);
    wr(9'h00C, 8'h00);
    cyc(1);
    wr(9'h00B, 8'h80);
    do_reset(1'b1);
    rdchk(9'h00B, 8'h00);
    rdchk(9'h00C, 8'h00);
    rdchk(9'h08C, 8'h00);
    port_pins_hi <= 4'h8;
    cyc(12);
    rdchk(9'h00B, 8'h01);
    do_reset(1'b0);
    rdchk(9'h00B, 8'h01);
    port_pins_hi <= 4'h0;
    cyc(12);
    read_req <= 1'b1;
    @(posedge clock);
    read_req <= 1'b0;
    wr(9'h00B, 8'h00);
    cyc(4);
    rdchk(9'h00B, 8'h00);
    for (int s = 0; s < 2; s++) begin
      edge_sel <= s[0];
      ext_irq_pin <= s[0];
      cyc(12);
      wr(9'h00B, 8'h00);
      ext_irq_pin <= !s[0];
      cyc(12);
      rdchk(9'h00B, 8'h00);
      ext_irq_pin <= s[0];
      cyc(12);
      rdchk(9'h00B, 8'h02);
    end
    wr(9'h00B, 8'h90);
    sleep_req <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b0;
    ext_irq_pin <= 1'b0;
    cyc(12);
    ext_irq_pin <= 1'b1;
    wait_take(n);
    chk({5'h0, depth}, 8'h01);
    test_done;
  end
endmodule
